// >>> core/twi_slave.sv
/*
 Slave end of the two-wire read port with a 2 x 256 byte store.
 Assumes link_clk_i oversamples SCL and SDA, clk_i faces the user,
 and prog_sel_i holds still around reset release.
*/
`timescale 1ns/1ps
`default_nettype none
`include "twi_map.svh"

module twi_slave (
	input  wire logic       link_clk_i,
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] prog_sel_i,
	twi_if.slave            bus,
	output logic            busy_o,
	output logic            byte_done_o
);
	// ****************************************
	// Crossings into the link domain
	// ****************************************
	logic       rst_l;
	logic [1:0] pins;
	logic [7:0] prog_s;

	twi_sync #(.W(1)) u_rst (
		.clk_i (link_clk_i),
		.d_i   (rst_i),
		.q_o   (rst_l)
	);

	// Oversampling at the link clock keeps both bus rates in reach
	twi_sync #(.W(2)) u_pins (
		.clk_i (link_clk_i),
		.d_i   ({bus.scl, bus.sda}),
		.q_o   (pins)
	);

	twi_sync #(.W(8)) u_prog (
		.clk_i (link_clk_i),
		.d_i   (prog_sel_i),
		.q_o   (prog_s)
	);

	// ****************************************
	// Link-side state
	// ****************************************
	twi_pkg::slv_link_t r_reg;
	twi_pkg::slv_link_t r_next;
	logic [7:0] mem [0:511];
	logic       wr_en;
	logic [8:0] wr_addr;
	logic [7:0] rd_data;
	logic       scl;
	logic       sda;
	logic       rise;
	logic       fall;
	logic       start_c;
	logic       stop_c;
	logic       hit_main;
	logic       hit_aux;

	assign scl     = pins[1];
	assign sda     = pins[0];
	assign rise    = scl & ~r_reg.scl_q;
	assign fall    = ~scl & r_reg.scl_q;
	assign start_c = scl & r_reg.scl_q & r_reg.sda_q & ~sda;
	assign stop_c  = scl & r_reg.scl_q & ~r_reg.sda_q & sda;
	assign rd_data = mem[{r_reg.bank, r_reg.ptr}];

	// Code nibble and seven address bits must agree
	assign hit_main = (r_reg.shreg[7:4] == `TWI_CTRL_CODE) &&
		((r_reg.shreg[7:1] == 7'(`TWI_MAIN_SEL >> 1)) ||
		(r_reg.shreg[7:1] == r_reg.prog[7:1]));
	assign hit_aux = (r_reg.shreg[7:1] == 7'(`TWI_AUX_SEL >> 1));

	always_comb
	begin
		r_next  = r_reg;
		wr_en   = 1'b0;
		wr_addr = {r_reg.bank, r_reg.ptr};
		r_next.scl_q = scl;
		r_next.sda_q = sda;
		// Programmed address is caught once after reset, like a strap
		if (!r_reg.prog_ok)
		begin
			r_next.prog    = prog_s;
			r_next.prog_ok = 1'b1;
		end
		if (start_c)
		begin
			r_next.state    = twi_pkg::S_ADDR;
			r_next.cnt      = 4'h0;
			r_next.sda_oe_n = 1'b1;
		end
		else if (stop_c)
		begin
			r_next.state    = twi_pkg::S_IDLE;
			r_next.sda_oe_n = 1'b1;
		end
		else
		begin
			case (r_reg.state)
				twi_pkg::S_ADDR, twi_pkg::S_RXD:
				begin
					if (rise)
					begin
						r_next.shreg = {r_reg.shreg[6:0], sda};
						r_next.cnt   = r_reg.cnt + 4'h1;
					end
					if (fall && r_reg.cnt == `TWI_BYTE_BITS)
					begin
						if (r_reg.state == twi_pkg::S_ADDR)
						begin
							if (hit_main || hit_aux)
							begin
								r_next.bank     = hit_aux;
								r_next.rw       = r_reg.shreg[`TWI_RW_BIT];
								r_next.from_sel = 1'b1;
								r_next.sda_oe_n = 1'b0;
								r_next.state    = twi_pkg::S_ACK;
							end
							else
							begin
								r_next.state = twi_pkg::S_IGN;
							end
						end
						else
						begin
							r_next.from_sel = 1'b0;
							r_next.sda_oe_n = 1'b0;
							r_next.state    = twi_pkg::S_ACK;
							if (r_reg.addr_phase)
							begin
								r_next.ptr        = r_reg.shreg;
								r_next.addr_phase = 1'b0;
							end
							else
							begin
								wr_en      = 1'b1;
								r_next.ptr = r_reg.ptr + 8'h01;
							end
						end
					end
				end
				twi_pkg::S_ACK:
				begin
					if (fall)
					begin
						r_next.tog = ~r_reg.tog;
						r_next.cnt = 4'h0;
						if (r_reg.from_sel && r_reg.rw)
						begin
							r_next.state    = twi_pkg::S_TXD;
							r_next.shreg    = rd_data;
							r_next.sda_oe_n = rd_data[7];
							r_next.ptr      = r_reg.ptr + 8'h01;
						end
						else
						begin
							r_next.state      = twi_pkg::S_RXD;
							r_next.sda_oe_n   = 1'b1;
							r_next.addr_phase = r_reg.from_sel | r_reg.addr_phase;
						end
					end
				end
				twi_pkg::S_TXD:
				begin
					if (rise)
					begin
						r_next.cnt = r_reg.cnt + 4'h1;
					end
					if (fall)
					begin
						if (r_reg.cnt == `TWI_BYTE_BITS)
						begin
							r_next.sda_oe_n = 1'b1;
							r_next.acked    = 1'b0;
							r_next.tog      = ~r_reg.tog;
							r_next.state    = twi_pkg::S_MACK;
						end
						else
						begin
							// Shift only while SCL is low so SDA never moves under a high SCL
							r_next.sda_oe_n = r_reg.shreg[6];
							r_next.shreg    = {r_reg.shreg[6:0], 1'b0};
						end
					end
				end
				twi_pkg::S_MACK:
				begin
					if (rise)
					begin
						r_next.acked = ~sda;
					end
					if (fall)
					begin
						if (r_reg.acked)
						begin
							r_next.state    = twi_pkg::S_TXD;
							r_next.cnt      = 4'h0;
							r_next.shreg    = rd_data;
							r_next.sda_oe_n = rd_data[7];
							r_next.ptr      = r_reg.ptr + 8'h01;
						end
						else
						begin
							r_next.state = twi_pkg::S_IGN;
						end
					end
				end
				default:
				begin
					r_next.sda_oe_n = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge link_clk_i)
	begin
		if (rst_l)
		begin
			r_reg <= '{state: twi_pkg::S_IDLE, cnt: 4'h0, shreg: 8'h00,
				ptr: 8'h00, bank: 1'b0, rw: 1'b0, from_sel: 1'b0,
				addr_phase: 1'b0, acked: 1'b0, sda_oe_n: 1'b1,
				scl_q: 1'b1, sda_q: 1'b1, tog: 1'b0,
				prog: `TWI_PROG_SEL_RST, prog_ok: 1'b0};
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	// Store has no reset: contents are undefined until written
	always_ff @(posedge link_clk_i)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= r_reg.shreg;
		end
	end

	assign bus.sda_s_o    = 1'b0;
	assign bus.sda_s_oe_n = r_reg.sda_oe_n;

	// ****************************************
	// Crossings into the user domain
	// ****************************************
	twi_pkg::slv_user_t u_reg;
	twi_pkg::slv_user_t u_next;
	logic               busy_l;
	logic               busy_s;
	logic               tog_s;

	assign busy_l = (r_reg.state != twi_pkg::S_IDLE) &&
		(r_reg.state != twi_pkg::S_IGN);

	twi_sync #(.W(2)) u_back (
		.clk_i (clk_i),
		.d_i   ({busy_l, r_reg.tog}),
		.q_o   ({busy_s, tog_s})
	);

	always_comb
	begin
		u_next       = u_reg;
		u_next.busy  = busy_s;
		u_next.tog_q = tog_s;
		u_next.done  = tog_s ^ u_reg.tog_q;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			u_reg <= '{busy: 1'b0, tog_q: 1'b0, done: 1'b0};
		end
		else
		begin
			u_reg <= u_next;
		end
	end

	assign busy_o      = u_reg.busy;
	assign byte_done_o = u_reg.done;
endmodule : twi_slave

`default_nettype wire

// >>> core/twi_map.svh
/*
 Constants of the two-wire read port: select codes, bus timing, reset values.
 Assumes inclusion by bare name from packages or modules that need them.
*/
`ifndef TWI_MAP_SVH
`define TWI_MAP_SVH

// ****************************************
// Select byte
// ****************************************
`define TWI_CTRL_CODE     4'ha
`define TWI_MAIN_SEL      8'ha2
`define TWI_AUX_SEL       8'ha0
`define TWI_PROG_SEL_RST  8'ha2
`define TWI_RW_BIT        0
`define TWI_BYTE_BITS     4'h8

// ****************************************
// Timing
// ****************************************
`define TWI_CLK_PERIOD_NS 25
`define TWI_SCL_STD_NS    10000
`define TWI_SCL_FAST_NS   2500
`define TWI_QTR_CYC(ns)   ((ns) / `TWI_CLK_PERIOD_NS / 4)

`endif

// >>> core/twi_pkg.sv
/*
 Types shared by both ends of the two-wire read port.
 Assumes twi_map.svh is on the include path.
*/
package twi_pkg;

	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_ADDR = 7'h02,
		S_ACK  = 7'h04,
		S_RXD  = 7'h08,
		S_TXD  = 7'h10,
		S_MACK = 7'h20,
		S_IGN  = 7'h40
	} slv_state_t;

	typedef enum logic [3:0] {
		M_IDLE  = 4'h1,
		M_START = 4'h2,
		M_STOP  = 4'h4,
		M_XFER  = 4'h8
	} mst_state_t;

	typedef enum logic [1:0] {
		OP_START = 2'h0,
		OP_STOP  = 2'h1,
		OP_WRITE = 2'h2,
		OP_READ  = 2'h3
	} op_t;

	typedef struct packed {
		slv_state_t state;
		logic [3:0] cnt;
		logic [7:0] shreg;
		logic [7:0] ptr;
		logic       bank;
		logic       rw;
		logic       from_sel;
		logic       addr_phase;
		logic       acked;
		logic       sda_oe_n;
		logic       scl_q;
		logic       sda_q;
		logic       tog;
		logic [7:0] prog;
		logic       prog_ok;
	} slv_link_t;

	typedef struct packed {
		logic busy;
		logic tog_q;
		logic done;
	} slv_user_t;

	typedef struct packed {
		mst_state_t state;
		op_t        op;
		logic [1:0] ph;
		logic [15:0] tick;
		logic [3:0] bitn;
		logic [7:0] txsh;
		logic [7:0] rxsh;
		logic [7:0] rdata;
		logic       nack;
		logic       ack;
		logic       done;
		logic       ready;
		logic       scl_oe_n;
		logic       sda_oe_n;
	} mst_t;

endpackage : twi_pkg

// >>> core/twi_if.sv
/*
 Two-wire bus between master and slave, resolved as wired-AND with pull-up.
 Assumes each party drives its output low only while its enable is low.
*/
`timescale 1ns/1ps
`default_nettype none

interface twi_if;
	logic scl_m_o;
	logic scl_m_oe_n;
	logic sda_m_o;
	logic sda_m_oe_n;
	logic sda_s_o;
	logic sda_s_oe_n;
	logic scl;
	logic sda;

	// Released lines read high through the pull-up
	assign scl = scl_m_oe_n | scl_m_o;
	assign sda = (sda_m_oe_n | sda_m_o) & (sda_s_oe_n | sda_s_o);

	modport master (
		output scl_m_o,
		output scl_m_oe_n,
		output sda_m_o,
		output sda_m_oe_n,
		input  scl,
		input  sda
	);

	modport slave (
		output sda_s_o,
		output sda_s_oe_n,
		input  scl,
		input  sda
	);
endinterface : twi_if

`default_nettype wire

// >>> core/twi_sync.sv
/*
 Two flip-flop synchroniser for levels entering a clock domain.
 Assumes multi-bit inputs are quasi-static while being sampled.
*/
`timescale 1ns/1ps
`default_nettype none

module twi_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;

	always_ff @(posedge clk_i)
	begin
		meta_reg <= d_i;
		q_reg    <= meta_reg;
	end

	assign q_o = q_reg;
endmodule : twi_sync

`default_nettype wire

// >>> core/twi_master.sv
/*
 Master end: makes SCL by dividing clk_i, runs start, stop, byte ops.
 Assumes one command at a time, taken while cmd_ready_o is high.
*/
`timescale 1ns/1ps
`default_nettype none
`include "twi_map.svh"

module twi_master #(
	parameter int SCL_PERIOD_NS = `TWI_SCL_STD_NS
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       cmd_valid_i,
	input  wire logic [1:0] cmd_op_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       nack_i,
	twi_if.master           bus,
	output logic            cmd_ready_o,
	output logic            done_o,
	output logic [7:0]      rdata_o,
	output logic            ack_o
);
	localparam logic [15:0] QTR = 16'(`TWI_QTR_CYC(SCL_PERIOD_NS) - 1);

	twi_pkg::mst_t r_reg;
	twi_pkg::mst_t r_next;
	logic          sda_s;

	twi_sync #(.W(1)) u_sda (
		.clk_i (clk_i),
		.d_i   (bus.sda),
		.q_o   (sda_s)
	);

	// SDA pull-down for a given bit slot; data moves only with SCL low
	function automatic logic pull(input twi_pkg::op_t op,
		input logic [3:0] bitn, input logic [7:0] tx, input logic nack);
		logic p;
		p = 1'b0;
		if (op == twi_pkg::OP_WRITE && bitn != `TWI_BYTE_BITS)
		begin
			p = ~tx[7];
		end
		else if (op == twi_pkg::OP_READ && bitn == `TWI_BYTE_BITS)
		begin
			p = ~nack;
		end
		return p;
	endfunction : pull

	always_comb
	begin
		r_next      = r_reg;
		r_next.done = 1'b0;
		case (r_reg.state)
			twi_pkg::M_IDLE:
			begin
				if (cmd_valid_i && r_reg.ready)
				begin
					r_next.op       = twi_pkg::op_t'(cmd_op_i);
					r_next.ready    = 1'b0;
					r_next.ph       = 2'h0;
					r_next.tick     = QTR;
					r_next.bitn     = 4'h0;
					r_next.txsh     = wdata_i;
					r_next.nack     = nack_i;
					r_next.scl_oe_n = 1'b0;
					case (twi_pkg::op_t'(cmd_op_i))
						twi_pkg::OP_START:
						begin
							r_next.state    = twi_pkg::M_START;
							r_next.sda_oe_n = 1'b1;
						end
						twi_pkg::OP_STOP:
						begin
							r_next.state    = twi_pkg::M_STOP;
							r_next.sda_oe_n = 1'b0;
						end
						default:
						begin
							r_next.state    = twi_pkg::M_XFER;
							r_next.sda_oe_n = ~pull(twi_pkg::op_t'(cmd_op_i),
								4'h0, wdata_i, nack_i);
						end
					endcase
				end
			end
			default:
			begin
				if (r_reg.tick != 16'h0000)
				begin
					r_next.tick = r_reg.tick - 16'h0001;
				end
				else
				begin
					r_next.tick = QTR;
					r_next.ph   = r_reg.ph + 2'h1;
					if (r_reg.ph == 2'h0)
					begin
						r_next.scl_oe_n = 1'b1;
					end
					if (r_reg.state == twi_pkg::M_START && r_reg.ph == 2'h1)
					begin
						r_next.sda_oe_n = 1'b0;
					end
					if (r_reg.state == twi_pkg::M_STOP && r_reg.ph == 2'h1)
					begin
						r_next.sda_oe_n = 1'b1;
					end
					if (r_reg.state == twi_pkg::M_XFER && r_reg.ph == 2'h1)
					begin
						if (r_reg.bitn == `TWI_BYTE_BITS)
						begin
							r_next.ack = ~sda_s;
						end
						else
						begin
							r_next.rxsh = {r_reg.rxsh[6:0], sda_s};
						end
					end
					if (r_reg.ph == 2'h2 && r_reg.state != twi_pkg::M_STOP)
					begin
						r_next.scl_oe_n = 1'b0;
					end
					if (r_reg.ph == 2'h3)
					begin
						if (r_reg.state != twi_pkg::M_XFER ||
							r_reg.bitn == `TWI_BYTE_BITS)
						begin
							r_next.state = twi_pkg::M_IDLE;
							r_next.done  = 1'b1;
							r_next.ready = 1'b1;
							r_next.rdata = r_reg.rxsh;
						end
						else
						begin
							r_next.bitn     = r_reg.bitn + 4'h1;
							r_next.txsh     = {r_reg.txsh[6:0], 1'b0};
							r_next.sda_oe_n = ~pull(r_reg.op, r_reg.bitn + 4'h1,
								{r_reg.txsh[6:0], 1'b0}, r_reg.nack);
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			r_reg <= '{state: twi_pkg::M_IDLE, op: twi_pkg::OP_START,
				ph: 2'h0, tick: 16'h0000, bitn: 4'h0, txsh: 8'h00,
				rxsh: 8'h00, rdata: 8'h00, nack: 1'b0, ack: 1'b0,
				done: 1'b0, ready: 1'b1, scl_oe_n: 1'b1, sda_oe_n: 1'b1};
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	assign bus.scl_m_o    = 1'b0;
	assign bus.scl_m_oe_n = r_reg.scl_oe_n;
	assign bus.sda_m_o    = 1'b0;
	assign bus.sda_m_oe_n = r_reg.sda_oe_n;
	assign cmd_ready_o    = r_reg.ready;
	assign done_o         = r_reg.done;
	assign rdata_o        = r_reg.rdata;
	assign ack_o          = r_reg.ack;
endmodule : twi_master

`default_nettype wire

// >>> sim/twi_properties.sv
/*
 Bus checker for the two-wire read port, sampled on the user clock.
 Assumes it sees the resolved bus and both parties' enables.
*/
`timescale 1ns/1ps
`default_nettype none

module twi_properties (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl,
	input wire logic sda,
	input wire logic scl_m_oe_n,
	input wire logic sda_m_oe_n,
	input wire logic sda_s_oe_n
);
	logic       scl_q;
	logic       sda_q;
	logic [7:0] rises;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// ****************************************
	// Clock rises since the last start
	// ****************************************
	always_ff @(posedge clk_i)
	begin
		scl_q <= scl;
		sda_q <= sda;
		if (rst_i || (scl && scl_q && sda_q && !sda))
			rises <= 8'h00;
		else if (scl && !scl_q && rises != 8'hff)
			rises <= rises + 8'h01;
	end

	// ****************************************
	// Properties
	// ****************************************
	a_slave_moves_low: assert property (
		$changed(sda_s_oe_n) |-> !scl)
		else $error("slave data moved while clock high");
	a_data_stable_high: assert property (
		scl && $past(scl) && $stable(sda_m_oe_n) |-> $stable(sda))
		else $error("data changed during clock high");
	a_start_slave_off: assert property (
		scl && $past(scl) && $fell(sda) |-> sda_s_oe_n)
		else $error("slave pulling data at start");
	a_stop_released: assert property (
		scl && $past(scl) && $rose(sda) |-> sda_s_oe_n && sda_m_oe_n)
		else $error("data not released at stop");
	a_scl_high_min: assert property (
		$rose(scl) |-> scl[*8])
		else $error("clock high phase too short");
	a_scl_low_min: assert property (
		$fell(scl) |-> (!scl)[*8])
		else $error("clock low phase too short");
	a_ack_after_byte: assert property (
		$fell(sda_s_oe_n) |-> rises >= 8'h08)
		else $error("slave pulled before a full byte");
	a_master_yields: assert property (
		!sda_s_oe_n && scl |-> sda_m_oe_n)
		else $error("master drives while slave owns data");

	c_start: cover property (scl && $past(scl) && $fell(sda));
	c_slave_pull: cover property ($rose(scl) && !sda_s_oe_n);
	c_stop: cover property (scl && $past(scl) && $rose(sda));
endmodule : twi_properties

`default_nettype wire

// >>> sim/testbench.sv
/*
 Self-checking bench: master and slave ends joined by one bus interface.
 Assumes the core files and the checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "twi_map.svh"

module testbench;
	logic       clk_i;
	logic       link_clk;
	logic       rst_i;
	logic       cmd_valid;
	logic [1:0] cmd_op;
	logic [7:0] wdata;
	logic       nack;
	logic [7:0] prog_sel;
	logic       cmd_ready_o;
	logic       done_o;
	logic [7:0] rdata_o;
	logic       ack_o;
	logic       busy_o;
	logic       byte_done;
	logic [8:0] wire_sh;
	int         nbd;
	int         mismatches;
	int         n_checks;

	twi_if bus_if ();

	twi_master #(.SCL_PERIOD_NS(`TWI_SCL_FAST_NS)) twi_master_i (
		.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid),
		.cmd_op_i(cmd_op), .wdata_i(wdata), .nack_i(nack),
		.bus(bus_if.master), .cmd_ready_o(cmd_ready_o),
		.done_o(done_o), .rdata_o(rdata_o), .ack_o(ack_o));
	twi_slave twi_slave_i (
		.link_clk_i(link_clk), .clk_i(clk_i), .rst_i(rst_i),
		.prog_sel_i(prog_sel), .bus(bus_if.slave), .busy_o(busy_o),
		.byte_done_o(byte_done));
	twi_properties twi_properties_i (
		.clk_i(clk_i), .rst_i(rst_i), .scl(bus_if.scl),
		.sda(bus_if.sda), .scl_m_oe_n(bus_if.scl_m_oe_n),
		.sda_m_oe_n(bus_if.sda_m_oe_n), .sda_s_oe_n(bus_if.sda_s_oe_n));

	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// Link clock offset by 7 ns; its edges still meet a user clock edge every 800 ns
	initial
	begin
		link_clk = 1'b0;
		#7;
		forever #32 link_clk = ~link_clk;
	end

	// Bits as seen on the wire, one per clock rise
	always @(posedge bus_if.scl) wire_sh <= {wire_sh[7:0], bus_if.sda};
	always @(negedge clk_i) if (byte_done === 1'b1) nbd <= nbd + 1;

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out

	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("FAIL %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// Reset with a new programmed select; it is caught once after release
	task automatic rst_pulse(input logic [7:0] sel);
		logic [7:0] st;
		rst_i = 1'b1;
		prog_sel = sel;
		repeat (6) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (20) @(negedge clk_i);
		st = {3'h0, busy_o, cmd_ready_o, done_o, bus_if.scl, bus_if.sda};
		chk(st, 8'h0b, "reset state");
	endtask : rst_pulse

	task automatic cmd(input logic [1:0] op, input logic [7:0] wd,
		input logic nk);
		int i;
		i = 0;
		while (cmd_ready_o !== 1'b1 && i < 4000)
		begin
			@(negedge clk_i);
			i++;
		end
		cmd_op = op;
		wdata = wd;
		nack = nk;
		cmd_valid = 1'b1;
		@(negedge clk_i);
		cmd_valid = 1'b0;
		while (done_o !== 1'b1 && i < 4000)
		begin
			@(negedge clk_i);
			i++;
		end
		if (i >= 4000)
		begin
			mismatches++;
			$display("FAIL %0t: command hung", $time);
			close_out();
		end
	endtask : cmd

	task automatic start;
		cmd(twi_pkg::OP_START, 8'h00, 1'b0);
	endtask : start

	task automatic stop;
		cmd(twi_pkg::OP_STOP, 8'h00, 1'b0);
		chk({6'h00, bus_if.scl, bus_if.sda}, 8'h03, "idle");
	endtask : stop

	task automatic wr(input logic [7:0] b, input logic ok);
		cmd(twi_pkg::OP_WRITE, b, 1'b0);
		chk(wire_sh[8:1], b, "wire byte");
		chk({7'h00, wire_sh[0]}, {7'h00, ~ok}, "wire ack");
		chk({7'h00, ack_o}, {7'h00, ok}, "ack");
	endtask : wr

	task automatic rd(input logic nk, input logic [7:0] exp);
		cmd(twi_pkg::OP_READ, 8'h00, nk);
		chk(rdata_o, exp, "read");
		chk(wire_sh[8:1], exp, "wire read");
		chk({7'h00, wire_sh[0]}, {7'h00, nk}, "end ack");
	endtask : rd

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_select;
		logic [7:0] sel [5];
		logic       ok [5];
		sel = '{8'ha2, 8'ha6, 8'ha0, 8'ha4, 8'hb2};
		ok = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
		for (int k = 0; k < 5; k++)
		begin
			start();
			wr(sel[k], ok[k]);
			chk({7'h00, busy_o}, {7'h00, ok[k]}, "busy");
			wr(8'ha2, ok[k]);
			stop();
			repeat (20) @(negedge clk_i);
			chk({7'h00, busy_o}, 8'h00, "busy after stop");
		end
		$display("select test done");
	endtask : test_select

	task automatic test_seq_wrap;
		int b0;
		b0 = nbd;
		start();
		wr(8'ha2, 1'b1);
		wr(8'hfe, 1'b1);
		wr(8'h55, 1'b1);
		wr(8'h66, 1'b1);
		wr(8'h77, 1'b1);
		wr(8'h88, 1'b1);
		stop();
		start();
		wr(8'ha2, 1'b1);
		wr(8'hfe, 1'b1);
		start();
		wr(8'ha3, 1'b1);
		rd(1'b0, 8'h55);
		rd(1'b0, 8'h66);
		rd(1'b1, 8'h77);
		stop();
		chk(8'(nbd - b0), 8'h0c, "byte pulses");
		$display("sequential wrap test done");
	endtask : test_seq_wrap

	task automatic test_current;
		start();
		wr(8'ha3, 1'b1);
		rd(1'b1, 8'h88);
		stop();
		$display("current address test done");
	endtask : test_current

	task automatic test_aux;
		start();
		wr(8'ha0, 1'b1);
		wr(8'h10, 1'b1);
		wr(8'h3c, 1'b1);
		stop();
		start();
		wr(8'ha0, 1'b1);
		wr(8'h10, 1'b1);
		start();
		wr(8'ha1, 1'b1);
		rd(1'b1, 8'h3c);
		stop();
		$display("aux bank test done");
	endtask : test_aux

	task automatic test_reprog;
		rst_pulse(8'hac);
		start();
		wr(8'hac, 1'b1);
		wr(8'h01, 1'b1);
		start();
		wr(8'had, 1'b1);
		rd(1'b1, 8'h88);
		stop();
		start();
		wr(8'ha6, 1'b0);
		stop();
		$display("programmed select test done");
	endtask : test_reprog

	initial
	begin
		cmd_valid = 1'b0;
		cmd_op = 2'h0;
		wdata = 8'h00;
		nack = 1'b0;
		wire_sh = 9'h000;
		nbd = 0;
		mismatches = 0;
		n_checks = 0;
		rst_pulse(8'ha6);
		test_select();
		test_seq_wrap();
		test_current();
		test_aux();
		test_reprog();
		close_out();
	end
endmodule : testbench

`default_nettype wire
